/* io_bus_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ====================================
// pin protocol checks
module io_bus_checker (
  input wire logic mclk_i,                 // clock
  input wire logic rst_n_i,                // sync reset
  input wire logic rom_write_enable_i,     // rom writes on
  input wire logic io_read_not_write_o,    // direction
  input wire logic io_read_strobe_n_o,     // read strobe
  input wire logic io_write_strobe_n_o,    // write strobe
  input wire logic rom_select_n_o,         // rom select
  input wire logic module_sel_n_o,         // module select
  input wire logic module_request_n_o,     // module request
  input wire logic module_grant_n_i,       // module grant
  input wire logic combo_dma_ack_n_o,      // dma ack
  input wire logic terminal_count_o,       // final word
  input wire logic upper_write_enable_n_o, // upper tx enable
  input wire logic slow_io_clock_o         // slow clock
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rd_dir;
    !io_read_strobe_n_o |-> io_read_not_write_o;
  endproperty
  a_rd_dir: assert property (p_rd_dir) else $error("read in write");
  property p_wr_dir;
    !io_write_strobe_n_o |-> !io_read_not_write_o;
  endproperty
  a_wr_dir: assert property (p_wr_dir) else $error("write in read");
  property p_dir_hold;
    !io_read_strobe_n_o || !io_write_strobe_n_o
      |-> $stable(io_read_not_write_o);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("dir moved");
  property p_mod_quiet;
    !module_sel_n_o |-> io_read_strobe_n_o && io_write_strobe_n_o;
  endproperty
  a_mod_quiet: assert property (p_mod_quiet) else $error("mod strobe");
  property p_rom_oe;
    $fell(rom_select_n_o) && io_read_not_write_o |=> !io_read_strobe_n_o;
  endproperty
  a_rom_oe: assert property (p_rom_oe) else $error("no rom oe");
  property p_rom_we;
    !io_write_strobe_n_o && !rom_select_n_o |-> rom_write_enable_i;
  endproperty
  a_rom_we: assert property (p_rom_we) else $error("rom we off");
  property p_grant;
    !module_request_n_o && !module_grant_n_i |=> module_request_n_o;
  endproperty
  a_grant: assert property (p_grant) else $error("req past grant");
  property p_req_sel;
    !module_request_n_o |-> !module_sel_n_o;
  endproperty
  a_req_sel: assert property (p_req_sel) else $error("req no select");
  property p_tc;
    terminal_count_o |-> !combo_dma_ack_n_o;
  endproperty
  a_tc: assert property (p_tc) else $error("count without ack");
  property p_uwe;
    !upper_write_enable_n_o |-> !io_write_strobe_n_o;
  endproperty
  a_uwe: assert property (p_uwe) else $error("upper tx off strobe");
  // two high, three low: a 2 MHz period
  property p_slow;
    $rose(slow_io_clock_o) |=> slow_io_clock_o ##1 !slow_io_clock_o [*3]
      ##1 slow_io_clock_o;
  endproperty
  a_slow: assert property (p_slow) else $error("slow clock shape");
  c_module: cover property ($fell(module_request_n_o));
  c_tc: cover property (terminal_count_o);
  c_rom_wr: cover property (!io_write_strobe_n_o && !rom_select_n_o);
endmodule
bind io_expansion_bus_control io_bus_checker io_bus_checker_inst (.*);
`default_nettype wire

/* io_bus_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ====================================
// peripheral model
module io_bus_partner #(
  parameter logic [15:0] LO = 16'h3c5a,
  parameter logic [15:0] HI = 16'ha5c3
) (
  input  wire logic        mclk_i,     // clock
  input  wire logic [15:0] dev_data_i, // device drive value
  input  wire logic        dev_oe_i,   // device drives bus
  input  wire logic        rd_n_i,     // read strobe
  input  wire logic        up_rd_n_i,  // upper read enable
  input  wire logic        req_n_i,    // module request
  input  wire logic        pc_sel_n_i, // PC area or extended PC select
  input  wire logic [3:0]  delay_i,    // answer delay
  output var  logic [15:0] data_o,     // bus level
  output var  logic        grant_n_o,  // module grant
  output var  logic        latch_n_o,  // module data valid
  output var  logic        ready_o     // pc wait
);
  logic [3:0]  cnt = 4'h0;
  logic [15:0] last = 16'h0000;
  // released bus toggles so a stale capture shows
  always_comb
    if (dev_oe_i) data_o = dev_data_i;
    else if (!rd_n_i || !req_n_i || !up_rd_n_i)
      data_o = up_rd_n_i ? LO : HI;
    else data_o = ~last;
  assign ready_o = pc_sel_n_i || cnt >= delay_i;
  always_ff @(posedge mclk_i)
  begin
    last <= data_o;
    cnt <= (!req_n_i || !pc_sel_n_i) ? cnt + 4'h1 : 4'h0;
    latch_n_o <= !(!req_n_i && cnt == delay_i);
    grant_n_o <= !(!req_n_i && cnt > delay_i);
  end
endmodule
`default_nettype wire

/* io_bus_pkg.sv */
package io_bus_pkg;

  // ==========================================================
  // timing
  localparam int CLK_HZ       = 10_000_000;
  localparam int CLK_NS       = 100;
  localparam int SETUP_NS     = 100;
  localparam int STROBE_NS    = 250;
  localparam int HOLD_NS      = 100;
  localparam int SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC     = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLOW_CLK_HZ  = 2_000_000;
  localparam int SLOW_DIV     = CLK_HZ / SLOW_CLK_HZ;

  // ==========================================================
  // address decode
  localparam int ADDR_W       = 16;
  localparam int REGION_LSB   = 12;
  localparam logic [3:0] REGION_ROM       = 4'h0;
  localparam logic [3:0] REGION_SIMPLE_A  = 4'h1;
  localparam logic [3:0] REGION_OPT_0     = 4'h2;
  localparam logic [3:0] REGION_OPT_1     = 4'h3;
  localparam logic [3:0] REGION_OPT_2     = 4'h4;
  localparam logic [3:0] REGION_PC_A      = 4'h5;
  localparam logic [3:0] REGION_PC_B      = 4'h6;
  localparam logic [3:0] REGION_COMBO     = 4'h7;
  localparam logic [3:0] REGION_COMBO_DMA = 4'h8;

  // ==========================================================
  // select vector bit positions
  localparam int SEL_ROM       = 0;
  localparam int SEL_SIMPLE_A  = 1;
  localparam int SEL_SIMPLE_B  = 2;
  localparam int SEL_MODULE    = 3;
  localparam int SEL_EXT_PC    = 4;
  localparam int SEL_PC_A      = 5;
  localparam int SEL_PC_B      = 6;
  localparam int SEL_COMBO     = 7;
  localparam int SEL_COMBO_DMA = 8;
  localparam int SEL_N         = 9;

  // ==========================================================
  // reset values
  localparam logic [SEL_N-1:0] SEL_IDLE_N  = 9'h1ff;
  localparam logic [15:0]      HALF_RESET  = 16'h0000;
  localparam logic [31:0]      WORD_RESET  = 32'h0000_0000;

  typedef enum {ST_IDLE, ST_LATCH, ST_SETUP, ST_STROBE,
                ST_MODULE, ST_UPPER, ST_HOLD} cycle_state_t;

  typedef enum {KIND_ROM, KIND_SIMPLE, KIND_PC, KIND_MODULE} cycle_kind_t;

endpackage

/* io_expansion_bus_control.sv */
`timescale 1ns/1ps
`default_nettype none
module io_expansion_bus_control
  import io_bus_pkg::*;
(
  input  wire logic              mclk_i,                  // 10 MHz clock
  input  wire logic              rst_n_i,                 // sync reset
  // internal request side
  input  wire logic              req_valid_i,             // request present
  output var  logic              req_ready_o,             // request taken
  input  wire logic              req_write_i,             // 1 write, 0 read
  input  wire logic              req_wide_i,              // 32-bit transfer
  input  wire logic              req_last_i,              // last DMA word
  input  wire logic [ADDR_W-1:0] req_addr_i,              // I/O address
  input  wire logic [31:0]       req_wdata_i,             // write word
  input  wire logic              rom_write_enable_i,      // ROM control bit
  // read answers
  output var  logic              rsp_valid_o,             // read word ready
  input  wire logic              rsp_ready_i,             // reader accepts
  output var  logic [31:0]       rsp_data_o,              // read word
  // pins
  input  wire logic [15:0]       io_data_bus_i,           // bus level
  output var  logic [15:0]       io_data_bus_o,           // bus drive value
  output var  logic              io_data_bus_oe_o,        // bus driven
  output var  logic              io_read_not_write_o,     // direction
  output var  logic              io_read_strobe_n_o,      // read strobe
  output var  logic              io_write_strobe_n_o,     // write strobe
  output var  logic              rom_select_n_o,          // ROM select
  output var  logic              simple_sel_a_n_o,        // simple select a
  output var  logic              simple_sel_b_n_o,        // simple select b
  output var  logic              module_sel_n_o,          // module select
  output var  logic              extended_pc_sel_n_o,     // ext PC select
  output var  logic              pc_area_sel_a_n_o,       // PC area a
  output var  logic              pc_area_sel_b_n_o,       // PC area b
  output var  logic              combo_sel_n_o,           // combo select
  output var  logic              combo_dma_ack_n_o,       // combo DMA ack
  output var  logic              terminal_count_o,        // final DMA word
  output var  logic              module_request_n_o,      // module request
  input  wire logic              module_grant_n_i,        // module grant
  input  wire logic              bus_latch_in_n_i,        // module data valid
  output var  logic              upper_latch_strobe_n_o,  // upper latch load
  output var  logic              upper_read_enable_n_o,   // upper rx enable
  output var  logic              upper_write_enable_n_o,  // upper tx enable
  input  wire logic              xip_halfword_select_n_i, // 0 upper half
  input  wire logic              xip_upper_capture_n_i,   // capture upper
  input  wire logic              decode_option_strap_i,   // decode option
  input  wire logic              io_ready_i,              // PC wait, low
  output var  logic              slow_io_clock_o          // 2 MHz clock
);

  // ==========================================================
  // state
  cycle_state_t     state, next_state;
  cycle_kind_t      kind, next_kind;
  logic [3:0]       cnt, next_cnt;
  logic             write, next_write;
  logic             wide, next_wide;
  logic [31:0]      wdata, next_wdata;
  logic [15:0]      lower, next_lower;
  logic [15:0]      upper, next_upper;
  logic [SEL_N-1:0] sel_n, next_sel_n;
  logic             strap;
  logic             push, next_push;
  logic             next_req_ready;
  logic             next_dir, next_rd_n, next_wr_n, next_tc;
  logic             next_req_n, next_blo_n, next_rbe_n, next_wbe_n;
  logic [15:0]      next_dout;
  logic             next_doe;
  logic [SEL_N-1:0] hot;
  logic [2:0]       div, next_div;
  logic             next_slow;

  word_stream_if #(.WIDTH(32)) rsp_s ();

  assign rsp_s.valid = push;
  assign rsp_s.data  = {upper, lower};

  skid_pair_buffer #(.WIDTH(32)) u_rsp_buf (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .in_s        (rsp_s),
    .out_valid_o (rsp_valid_o),
    .out_ready_i (rsp_ready_i),
    .out_data_o  (rsp_data_o)
  );

  // ==========================================================
  // decode
  function automatic logic [SEL_N-1:0] decode_region(
    input logic [3:0] region,
    input logic       opt
  );
    logic [SEL_N-1:0] h;
    h = '0;
    case (region)
      REGION_ROM:       h[SEL_ROM] = 1'b1;
      REGION_SIMPLE_A:  h[SEL_SIMPLE_A] = 1'b1;
      REGION_OPT_0:     h[opt ? SEL_MODULE : SEL_SIMPLE_B] = 1'b1;
      REGION_OPT_1:     h[opt ? SEL_EXT_PC : SEL_MODULE] = 1'b1;
      REGION_OPT_2:     h[opt ? SEL_SIMPLE_B : SEL_EXT_PC] = 1'b1;
      REGION_PC_A:      h[SEL_PC_A] = 1'b1;
      REGION_PC_B:      h[SEL_PC_B] = 1'b1;
      REGION_COMBO:     h[SEL_COMBO] = 1'b1;
      REGION_COMBO_DMA: h[SEL_COMBO_DMA] = 1'b1;
      default:          h = '0;
    endcase
    return h;
  endfunction

  // unmapped regions run simple timing with no select
  function automatic cycle_kind_t kind_of(input logic [SEL_N-1:0] h);
    if (h[SEL_ROM])
      return KIND_ROM;
    if (h[SEL_MODULE])
      return KIND_MODULE;
    if (h[SEL_EXT_PC] || h[SEL_PC_A] || h[SEL_PC_B] ||
        h[SEL_COMBO] || h[SEL_COMBO_DMA])
      return KIND_PC;
    return KIND_SIMPLE;
  endfunction

  // strap is static: caught while reset is held
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      strap <= decode_option_strap_i;
  end

  // ==========================================================
  // cycle sequencer
  always_comb
  begin
    hot            = decode_region(req_addr_i[ADDR_W-1:REGION_LSB], strap);
    next_state     = state;
    next_kind      = kind;
    next_cnt       = cnt;
    next_write     = write;
    next_wide      = wide;
    next_wdata     = wdata;
    next_lower     = lower;
    next_upper     = upper;
    next_sel_n     = sel_n;
    next_push      = 1'b0;
    next_dir       = io_read_not_write_o;
    next_rd_n      = io_read_strobe_n_o;
    next_wr_n      = io_write_strobe_n_o;
    next_tc        = terminal_count_o;
    next_req_n     = module_request_n_o;
    next_blo_n     = upper_latch_strobe_n_o;
    next_rbe_n     = upper_read_enable_n_o;
    next_wbe_n     = upper_write_enable_n_o;
    next_dout      = io_data_bus_o;
    next_doe       = io_data_bus_oe_o;
    unique case (state)
      ST_IDLE:
      begin
        if (req_valid_i && req_ready_o)
        begin
          next_kind  = kind_of(hot);
          next_write = req_write_i;
          next_wide  = req_wide_i;
          next_wdata = req_wdata_i;
          next_upper = HALF_RESET;
          next_lower = HALF_RESET;
          next_sel_n = ~hot;
          next_tc    = req_last_i && hot[SEL_COMBO_DMA];
          next_dir   = !req_write_i;
          next_doe   = req_write_i;
          next_cnt   = 4'(SETUP_CYC - 1);
          if (req_write_i && req_wide_i)
          begin
            // upper half goes first into the external latches
            next_dout  = req_wdata_i[31:16];
            next_blo_n = 1'b0;
            next_state = ST_LATCH;
          end
          else
          begin
            next_dout  = xip_halfword_select_n_i ? req_wdata_i[15:0]
                                                 : req_wdata_i[31:16];
            next_state = ST_SETUP;
          end
        end
      end
      ST_LATCH:
      begin
        next_blo_n = 1'b1;
        next_dout  = wdata[15:0];
        next_state = ST_SETUP;
      end
      ST_SETUP:
      begin
        if (cnt != 4'h0)
          next_cnt = cnt - 4'h1;
        else if (kind == KIND_MODULE)
        begin
          next_req_n = 1'b0;
          next_state = ST_MODULE;
        end
        else
        begin
          next_cnt   = 4'(STROBE_CYC - 1);
          next_state = ST_STROBE;
          if (!write)
            next_rd_n = 1'b0;
          else
          begin
            next_wr_n  = (kind == KIND_ROM) && !rom_write_enable_i;
            next_wbe_n = !wide;
          end
        end
      end
      ST_STROBE:
      begin
        if (cnt != 4'h0)
          next_cnt = cnt - 4'h1;
        else if (kind == KIND_PC && !io_ready_i)
          next_cnt = cnt;
        else
        begin
          next_wr_n  = 1'b1;
          next_wbe_n = 1'b1;
          if (!write)
            next_lower = io_data_bus_i;
          if (!write && wide)
          begin
            // read strobe held while the upper half answers
            next_rbe_n = 1'b0;
            next_cnt   = 4'(STROBE_CYC - 1);
            next_state = ST_UPPER;
          end
          else
          begin
            next_rd_n  = 1'b1;
            next_cnt   = 4'(HOLD_CYC - 1);
            next_state = ST_HOLD;
          end
        end
      end
      ST_UPPER:
      begin
        if (cnt != 4'h0)
          next_cnt = cnt - 4'h1;
        else
        begin
          next_upper = io_data_bus_i;
          next_rbe_n = 1'b1;
          next_rd_n  = 1'b1;
          next_cnt   = 4'(HOLD_CYC - 1);
          next_state = ST_HOLD;
        end
      end
      ST_MODULE:
      begin
        // no timeout: a module that never grants holds the bus
        if (!write && !bus_latch_in_n_i)
          next_lower = io_data_bus_i;
        if (!module_grant_n_i)
        begin
          next_req_n = 1'b1;
          next_cnt   = 4'(HOLD_CYC - 1);
          next_state = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (cnt != 4'h0)
          next_cnt = cnt - 4'h1;
        else
        begin
          next_sel_n = SEL_IDLE_N;
          next_tc    = 1'b0;
          next_doe   = 1'b0;
          next_push  = !write;
          next_state = ST_IDLE;
        end
      end
    endcase
    if (state != ST_IDLE && !write && !xip_upper_capture_n_i)
      next_upper = io_data_bus_i;
    // no take while a push is pending
    next_req_ready = (next_state == ST_IDLE) && rsp_s.ready && !next_push;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      state                  <= ST_IDLE;
      kind                   <= KIND_SIMPLE;
      cnt                    <= 4'h0;
      write                  <= 1'b0;
      wide                   <= 1'b0;
      wdata                  <= WORD_RESET;
      lower                  <= HALF_RESET;
      upper                  <= HALF_RESET;
      sel_n                  <= SEL_IDLE_N;
      push                   <= 1'b0;
      req_ready_o            <= 1'b0;
      io_read_not_write_o    <= 1'b1;
      io_read_strobe_n_o     <= 1'b1;
      io_write_strobe_n_o    <= 1'b1;
      terminal_count_o       <= 1'b0;
      module_request_n_o     <= 1'b1;
      upper_latch_strobe_n_o <= 1'b1;
      upper_read_enable_n_o  <= 1'b1;
      upper_write_enable_n_o <= 1'b1;
      io_data_bus_o          <= HALF_RESET;
      io_data_bus_oe_o       <= 1'b0;
    end
    else
    begin
      state                  <= next_state;
      kind                   <= next_kind;
      cnt                    <= next_cnt;
      write                  <= next_write;
      wide                   <= next_wide;
      wdata                  <= next_wdata;
      lower                  <= next_lower;
      upper                  <= next_upper;
      sel_n                  <= next_sel_n;
      push                   <= next_push;
      req_ready_o            <= next_req_ready;
      io_read_not_write_o    <= next_dir;
      io_read_strobe_n_o     <= next_rd_n;
      io_write_strobe_n_o    <= next_wr_n;
      terminal_count_o       <= next_tc;
      module_request_n_o     <= next_req_n;
      upper_latch_strobe_n_o <= next_blo_n;
      upper_read_enable_n_o  <= next_rbe_n;
      upper_write_enable_n_o <= next_wbe_n;
      io_data_bus_o          <= next_dout;
      io_data_bus_oe_o       <= next_doe;
    end
  end

  assign rom_select_n_o      = sel_n[SEL_ROM];
  assign simple_sel_a_n_o    = sel_n[SEL_SIMPLE_A];
  assign simple_sel_b_n_o    = sel_n[SEL_SIMPLE_B];
  assign module_sel_n_o      = sel_n[SEL_MODULE];
  assign extended_pc_sel_n_o = sel_n[SEL_EXT_PC];
  assign pc_area_sel_a_n_o   = sel_n[SEL_PC_A];
  assign pc_area_sel_b_n_o   = sel_n[SEL_PC_B];
  assign combo_sel_n_o       = sel_n[SEL_COMBO];
  assign combo_dma_ack_n_o   = sel_n[SEL_COMBO_DMA];

  // ==========================================================
  // low-rate clock: high two of every five
  always_comb
  begin
    next_div  = (div == 3'(SLOW_DIV - 1)) ? 3'h0 : div + 3'h1;
    next_slow = next_div < 3'(SLOW_DIV / 2);
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      div             <= 3'(SLOW_DIV - 1);
      slow_io_clock_o <= 1'b0;
    end
    else
    begin
      div             <= next_div;
      slow_io_clock_o <= next_slow;
    end
  end

endmodule
`default_nettype wire

/* skid_pair_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
module skid_pair_buffer
  import io_bus_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  input  wire logic             mclk_i,    // system clock
  input  wire logic             rst_n_i,   // sync reset, active low
  word_stream_if.snk            in_s,      // filling side
  output var  logic             out_valid_o, // word available
  input  wire logic             out_ready_i, // drain side accepts
  output var  logic [WIDTH-1:0] out_data_o   // word
);

  logic             skid_valid;
  logic [WIDTH-1:0] skid_data;
  logic             next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic             next_skid_valid;
  logic [WIDTH-1:0] next_skid_data;

  // ==========================================================
  // output register plus skid register
  assign in_s.ready = !skid_valid;

  always_comb
  begin
    next_out_valid  = out_valid_o;
    next_out_data   = out_data_o;
    next_skid_valid = skid_valid;
    next_skid_data  = skid_data;
    if (!out_valid_o || out_ready_i)
    begin
      if (skid_valid)
      begin
        next_out_valid  = 1'b1;
        next_out_data   = skid_data;
        next_skid_valid = 1'b0;
      end
      else
      begin
        next_out_valid = in_s.valid;
        next_out_data  = in_s.data;
      end
    end
    else if (in_s.valid && !skid_valid)
    begin
      next_skid_valid = 1'b1;
      next_skid_data  = in_s.data;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
      skid_valid  <= 1'b0;
      skid_data   <= '0;
    end
    else
    begin
      out_valid_o <= next_out_valid;
      out_data_o  <= next_out_data;
      skid_valid  <= next_skid_valid;
      skid_data   <= next_skid_data;
    end
  end

endmodule
`default_nettype wire

/* tb_io_expansion_bus_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_io_expansion_bus_control;
  import io_bus_pkg::*;
  localparam logic [15:0] LO = 16'h3c5a;
  localparam logic [15:0] HI = 16'ha5c3;
  localparam logic [31:0] Z = 32'h0000_0000;
  logic mclk_i = 0, rst_n_i = 0, req_valid_i = 0, req_write_i = 0;
  logic req_wide_i = 0, req_last_i = 0, rom_write_enable_i = 0;
  logic rsp_ready_i = 1, xip_sel_n = 1, xip_cap_n = 1, strap = 0, taken;
  logic [15:0] req_addr_i = 16'h0000;
  logic [31:0] req_wdata_i = Z;
  logic [3:0]  slow = 4'h0;
  logic [15:0] bus_in, bus_out, wr_lo, wr_hi;
  logic [31:0] rsp_data_o, rsp_seen;
  logic [8:0]  sel_n, seen;
  logic req_ready_o, rsp_valid_o, oe, rd_n, wr_n, tc, req_n, grant_n;
  logic latch_n, up_rd_n, ready, blo_n;
  int   n_sel, n_wstb, n_rsp, tc_seen, error_cnt = 0, n_compared = 0;
  always #50 mclk_i = ~mclk_i;
  io_expansion_bus_control io_expansion_bus_control_inst (
    .mclk_i, .rst_n_i, .req_valid_i, .req_ready_o, .req_write_i,
    .req_wide_i, .req_last_i, .req_addr_i, .req_wdata_i,
    .rom_write_enable_i, .rsp_valid_o, .rsp_ready_i, .rsp_data_o,
    .io_data_bus_i(bus_in), .io_data_bus_o(bus_out),
    .io_data_bus_oe_o(oe), .io_read_not_write_o(),
    .io_read_strobe_n_o(rd_n), .io_write_strobe_n_o(wr_n),
    .rom_select_n_o(sel_n[SEL_ROM]), .simple_sel_a_n_o(sel_n[SEL_SIMPLE_A]),
    .simple_sel_b_n_o(sel_n[SEL_SIMPLE_B]),
    .module_sel_n_o(sel_n[SEL_MODULE]), .extended_pc_sel_n_o(sel_n[SEL_EXT_PC]),
    .pc_area_sel_a_n_o(sel_n[SEL_PC_A]), .pc_area_sel_b_n_o(sel_n[SEL_PC_B]),
    .combo_sel_n_o(sel_n[SEL_COMBO]),
    .combo_dma_ack_n_o(sel_n[SEL_COMBO_DMA]), .terminal_count_o(tc),
    .module_request_n_o(req_n), .module_grant_n_i(grant_n),
    .bus_latch_in_n_i(latch_n), .upper_latch_strobe_n_o(blo_n),
    .upper_read_enable_n_o(up_rd_n), .upper_write_enable_n_o(),
    .xip_halfword_select_n_i(xip_sel_n), .xip_upper_capture_n_i(xip_cap_n),
    .decode_option_strap_i(strap), .io_ready_i(ready), .slow_io_clock_o());
  io_bus_partner #(.LO(LO), .HI(HI)) io_bus_partner_inst (
    .mclk_i, .dev_data_i(bus_out), .dev_oe_i(oe), .rd_n_i(rd_n),
    .up_rd_n_i(up_rd_n), .req_n_i(req_n), .delay_i(slow),
    .pc_sel_n_i(sel_n[SEL_PC_A] & sel_n[SEL_PC_B] & sel_n[SEL_EXT_PC]),
    .data_o(bus_in), .grant_n_o(grant_n), .latch_n_o(latch_n),
    .ready_o(ready));
  // ====================================
  // pin monitor
  always @(posedge mclk_i)
  begin
    seen <= seen | ~sel_n;
    n_sel <= n_sel + int'(sel_n != 9'h1ff);
    n_wstb <= n_wstb + int'(!wr_n);
    tc_seen <= tc_seen | int'(tc);
    if (!wr_n) wr_lo <= bus_out;
    if (!blo_n) wr_hi <= bus_out;
    if (rsp_valid_o && rsp_ready_i) rsp_seen <= rsp_data_o;
    n_rsp <= n_rsp + int'(rsp_valid_o && rsp_ready_i);
  end
  task automatic check(input string what, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic rst(input logic s);
    strap = s;
    rst_n_i = 0;
    repeat (20) @(posedge mclk_i);
    #1 rst_n_i = 1;
  endtask
  task automatic do_req(input logic [15:0] a, input logic w, wd, lst,
                        input logic [31:0] d);
    int i;
    {seen, n_sel, n_wstb, tc_seen} = '0;
    {req_addr_i, req_write_i, req_wide_i, req_last_i} = {a, w, wd, lst};
    req_wdata_i = d;
    req_valid_i = 1;
    i = 0;
    while (req_ready_o !== 1'b1 && i++ < 30) @(posedge mclk_i) #1;
    taken = req_ready_o === 1'b1;
    if (!taken) return;
    @(posedge mclk_i) #1;
    req_valid_i = 0;
    i = 0;
    while (req_ready_o !== 1'b1 && i++ < 60) @(posedge mclk_i) #1;
    @(posedge mclk_i) #1;
  endtask
  function automatic logic [8:0] exp_sel(input int r, input logic s);
    int k;
    k = r == 0 ? SEL_ROM : r == 1 ? SEL_SIMPLE_A : r == 5 ? SEL_PC_A :
        r == 6 ? SEL_PC_B : r == 7 ? SEL_COMBO : SEL_COMBO_DMA;
    if (r == 2) k = s ? SEL_MODULE : SEL_SIMPLE_B;
    if (r == 3) k = s ? SEL_EXT_PC : SEL_MODULE;
    if (r == 4) k = s ? SEL_SIMPLE_B : SEL_EXT_PC;
    return 9'h001 << k;
  endfunction
  // ====================================
  // scenarios
  task automatic t_rom();
    do_req(16'h0010, 1, 0, 0, Z);
    check("rom write blocked", n_wstb, 0);
    rom_write_enable_i = 1;
    do_req(16'h0010, 1, 0, 0, Z);
    check("rom write strobe", n_wstb, STROBE_CYC);
    do_req(16'h0010, 0, 0, 0, Z);
    check("rom select span", n_sel, SETUP_CYC + STROBE_CYC + HOLD_CYC);
    check("rom read", rsp_seen[15:0], LO);
  endtask
  task automatic t_xip_wide();
    xip_sel_n = 0;
    do_req(16'h1010, 1, 0, 0, 32'hbeef_0123);
    check("xip upper", wr_lo, 16'hbeef);
    xip_sel_n = 1;
    do_req(16'h1010, 1, 0, 0, 32'hbeef_0123);
    check("xip lower", wr_lo, 16'h0123);
    do_req(16'h1010, 1, 1, 0, 32'h1357_9bdf);
    check("wide upper", wr_hi, 16'h1357);
    check("wide lower", wr_lo, 16'h9bdf);
    do_req(16'h1010, 0, 1, 0, Z);
    check("wide read", rsp_seen, {HI, LO});
    xip_cap_n = 0;
    do_req(16'h1010, 0, 0, 0, Z);
    xip_cap_n = 1;
    check("xip capture", rsp_seen, {~LO, LO});
  endtask
  task automatic t_pc_module();
    int base;
    do_req(16'h5010, 0, 0, 0, Z);
    base = n_sel;
    slow = 4'h4;
    do_req(16'h5010, 0, 0, 0, Z);
    check("pc stretch", n_sel > base, 1);
    check("pc read", rsp_seen[15:0], LO);
    do_req(16'h3010, 0, 0, 0, Z);
    check("module read", rsp_seen[15:0], LO);
    slow = 4'h0;
  endtask
  task automatic t_dma();
    do_req(16'h8010, 1, 0, 1, Z);
    check("tc on last", tc_seen, 1);
    check("dma ack", seen, exp_sel(8, 0));
    do_req(16'h8010, 1, 0, 0, Z);
    check("tc not last", tc_seen, 0);
  endtask
  task automatic t_buffer();
    rsp_ready_i = 0;
    n_rsp = 0;
    do_req(16'h1010, 0, 0, 0, Z);
    do_req(16'h1010, 0, 0, 0, Z);
    do_req(16'h1010, 0, 0, 0, Z);
    check("full refuses", taken, 0);
    rsp_ready_i = 1;
    do_req(16'h1010, 0, 0, 0, Z);
    check("words drained", n_rsp, 3);
    check("empty", rsp_valid_o, 0);
  endtask
  task automatic t_decode(input logic s);
    rst(s);
    for (int r = 0; r < 9; r++)
    begin
      do_req({4'(r), 12'h010}, 0, 0, 0, Z);
      check("decode", seen, exp_sel(r, s));
    end
  endtask
  initial
  begin
    rst(1'b0);
    t_rom();
    t_xip_wide();
    t_pc_module();
    t_dma();
    t_buffer();
    t_decode(1'b0);
    t_decode(1'b1);
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire

/* word_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface word_stream_if #(parameter int WIDTH = 32);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire
